/* File: cso_pkg.sv */
// constants for the core status, option and interrupt control registers
package cso_pkg;
    // mirrored addresses, matched on the low address bits
    localparam logic [6:0] STATUS_LOW = 7'h03;
    localparam logic [7:0] OPTION_LOW = 8'h81;
    localparam logic [6:0] INTCTL_LOW = 7'h0B;
    localparam logic [8:0] STATUS_ADDR = 9'h003;
    localparam logic [8:0] OPTION_ADDR = 9'h081;
    localparam logic [8:0] INTCTL_ADDR = 9'h00B;
    localparam logic [8:0] OPTION_MIRROR = 9'h181;
    // arith_reset_status fields
    localparam int ST_BANK_HI = 7;
    localparam int ST_BANK_LO = 5;
    localparam int ST_TIMEOUT = 4;
    localparam int ST_POWERDOWN = 3;
    localparam int ST_ZERO = 2;
    localparam int ST_NIBBLE = 1;
    localparam int ST_CARRY = 0;
    // timer_config_reg fields
    localparam int OP_PULLUP_DIS = 7;
    localparam int OP_EXT_EDGE = 6;
    localparam int OP_T0_SRC = 5;
    localparam int OP_T0_EDGE = 4;
    localparam int OP_PRESC_OWNER = 3;
    localparam int OP_RATE_HI = 2;
    // irq_control_reg fields
    localparam int IC_GLOBAL_EN = 7;
    localparam int IC_PERIPH_EN = 6;
    localparam int IC_T0_EN = 5;
    localparam int IC_EXT_EN = 4;
    localparam int IC_PORT_EN = 3;
    localparam int IC_T0_FLAG = 2;
    localparam int IC_EXT_FLAG = 1;
    localparam int IC_PORT_FLAG = 0;
    // reset values
    localparam logic [7:0] STATUS_RST = 8'h18;
    localparam logic [7:0] OPTION_RST = 8'hFF;
    localparam logic [7:0] INTCTL_RST = 8'h00;
    localparam logic [7:0] PRESC_RST = 8'h00;
endpackage : cso_pkg

/* File: cso_presc_if.sv */
// link between the register core and the timer0/watchdog prescaler
`timescale 1ns/1ps
interface cso_presc_if;
    logic timer_ext_clock_pin;
    logic timer0_source_select;
    logic timer0_edge_select;
    logic prescaler_owner;
    logic [2:0] prescale_rate;
    logic cycle_tick;
    logic wdt_base_tick;
    logic timer0_inc;
    logic wdt_inc;
    modport core (
        output timer_ext_clock_pin, timer0_source_select, timer0_edge_select,
        output prescaler_owner, prescale_rate, cycle_tick, wdt_base_tick,
        input timer0_inc, wdt_inc
    );
    modport presc (
        input timer_ext_clock_pin, timer0_source_select, timer0_edge_select,
        input prescaler_owner, prescale_rate, cycle_tick, wdt_base_tick,
        output timer0_inc, wdt_inc
    );
endinterface : cso_presc_if

/* File: cso_prescaler.sv */
// shared prescaler and timer0 clock source selection
`timescale 1ns/1ps
module cso_prescaler (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // core link
    cso_presc_if.presc p
);
    logic pin_meta_r, pin_meta_nxt;
    logic pin_sync_r, pin_sync_nxt;
    logic pin_prev_r, pin_prev_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic t0_inc_r, t0_inc_nxt;
    logic wdt_inc_r, wdt_inc_nxt;
    logic ext_evt, src_evt, presc_in, hit;
    logic [3:0] shift;
    logic [8:0] mask;
    logic [7:0] cnt_inc;

    always_comb begin
        pin_meta_nxt = p.timer_ext_clock_pin;
        pin_sync_nxt = pin_meta_r;
        pin_prev_nxt = pin_sync_r;
        ext_evt = p.timer0_edge_select ? (pin_prev_r & ~pin_sync_r)
                                       : (~pin_prev_r & pin_sync_r);
        src_evt = p.timer0_source_select ? ext_evt : p.cycle_tick;
        presc_in = p.prescaler_owner ? p.wdt_base_tick : src_evt;
        shift = p.prescaler_owner ? {1'b0, p.prescale_rate}
                                  : 4'({1'b0, p.prescale_rate} + 4'h1);
        mask = 9'((9'h001 << shift) - 9'h001);
        cnt_inc = 8'(cnt_r + 8'h01);
        hit = presc_in && ((cnt_inc & mask[7:0]) == 8'h00);
        cnt_nxt = presc_in ? cnt_inc : cnt_r;
        // undivided timer when watchdog owns it
        t0_inc_nxt = p.prescaler_owner ? src_evt : hit;
        wdt_inc_nxt = p.prescaler_owner ? hit : p.wdt_base_tick;
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            pin_meta_r <= 1'b0;
            pin_sync_r <= 1'b0;
            pin_prev_r <= 1'b0;
            cnt_r <= cso_pkg::PRESC_RST;
            t0_inc_r <= 1'b0;
            wdt_inc_r <= 1'b0;
        end else begin
            pin_meta_r <= pin_meta_nxt;
            pin_sync_r <= pin_sync_nxt;
            pin_prev_r <= pin_prev_nxt;
            cnt_r <= cnt_nxt;
            t0_inc_r <= t0_inc_nxt;
            wdt_inc_r <= wdt_inc_nxt;
        end
    end

    assign p.timer0_inc = t0_inc_r;
    assign p.wdt_inc = wdt_inc_r;
endmodule : cso_prescaler

/* File: cso_core_regs.sv */
// core status, option and interrupt control registers
// Operation
// - flag-updating instructions load zero, nibble and carry bits from flag logic
// - timeout and powerdown bits ignore writes; only reset, sleep, watchdog change them
// - clear of status zeroes bank bits, sets zero, keeps the rest
// - in subtraction carry and nibble bits read as active-low borrows
// - status register appears at the same storage in every bank
// - option register is read/write and mirrored at two addresses
// - bit 7 high disables pull-ups, else latch values enable them
// - bit 6 picks rising or falling external interrupt edge
// - bit 5 picks timer pin transitions or instruction cycle clock
// - bit 4 picks falling or rising edge on timer pin
// - bit 3 gives prescaler to watchdog, timer then counts undivided
// - interrupt control holds enables and flags for three sources, read/write
// - flags set on their condition regardless of any enable
// - external pin flag stays set until software clears it
// - peripheral interrupts need the peripheral enable bit at position 6
`timescale 1ns/1ps
module cso_core_regs (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // register access from the instruction datapath
    input wire logic [8:0] addr_i,
    input wire logic wr_en_i,
    input wire logic clr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic rd_en_i,
    output logic [7:0] rd_data_o,
    // arithmetic flag logic
    input wire logic [2:0] flag_upd_i,
    input wire logic alu_sub_i,
    input wire logic alu_zero_i,
    input wire logic alu_nibble_i,
    input wire logic alu_carry_i,
    // sleep and watchdog events
    input wire logic sleep_i,
    input wire logic wdt_timeout_i,
    input wire logic wdt_clear_i,
    // pins and timer events
    input wire logic ext_irq_pin_i,
    input wire logic timer_ext_clock_pin_i,
    input wire logic cycle_tick_i,
    input wire logic wdt_base_tick_i,
    input wire logic timer0_ovf_i,
    input wire logic port_change_i,
    input wire logic periph_irq_i,
    input wire logic [7:0] port_latch_i,
    // outputs
    output logic [2:0] bank_sel_o,
    output logic [7:0] pullup_en_o,
    output logic timer0_inc_o,
    output logic wdt_inc_o,
    output logic irq_o
);
    logic [7:0] status_r, status_nxt;
    logic [7:0] option_r, option_nxt;
    logic [7:0] intctl_r, intctl_nxt;
    logic [7:0] rd_data_r, rd_data_nxt;
    logic [7:0] pullup_r, pullup_nxt;
    logic irq_r, irq_nxt;
    logic t0_inc_r, t0_inc_nxt;
    logic wdt_inc_r, wdt_inc_nxt;
    logic ext_meta_r, ext_meta_nxt;
    logic ext_sync_r, ext_sync_nxt;
    logic ext_prev_r, ext_prev_nxt;
    logic hit_status, hit_option, hit_intctl;
    logic ext_edge;
    logic [7:0] wdata;
    logic [2:0] alu_flags;

    cso_presc_if presc_link ();

    assign presc_link.timer_ext_clock_pin = timer_ext_clock_pin_i;
    assign presc_link.timer0_source_select = option_r[cso_pkg::OP_T0_SRC];
    assign presc_link.timer0_edge_select = option_r[cso_pkg::OP_T0_EDGE];
    assign presc_link.prescaler_owner = option_r[cso_pkg::OP_PRESC_OWNER];
    assign presc_link.prescale_rate = option_r[cso_pkg::OP_RATE_HI:0];
    assign presc_link.cycle_tick = cycle_tick_i;
    assign presc_link.wdt_base_tick = wdt_base_tick_i;

    cso_prescaler u_presc (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .p(presc_link.presc)
    );

    // address decode
    always_comb begin
        hit_status = (addr_i[6:0] == cso_pkg::STATUS_LOW);
        hit_option = (addr_i[7:0] == cso_pkg::OPTION_LOW);
        hit_intctl = (addr_i[6:0] == cso_pkg::INTCTL_LOW);
        wdata = clr_i ? 8'h00 : wr_data_i;
        alu_flags = {alu_zero_i, alu_nibble_i ^ alu_sub_i, alu_carry_i ^ alu_sub_i};
    end

    // status register
    always_comb begin
        status_nxt = status_r;
        if (wdt_clear_i) begin
            status_nxt[cso_pkg::ST_TIMEOUT] = 1'b1;
            status_nxt[cso_pkg::ST_POWERDOWN] = 1'b1;
        end else if (sleep_i) begin
            status_nxt[cso_pkg::ST_TIMEOUT] = 1'b1;
            status_nxt[cso_pkg::ST_POWERDOWN] = 1'b0;
        end
        if (wdt_timeout_i) begin
            status_nxt[cso_pkg::ST_TIMEOUT] = 1'b0;
        end
        if (wr_en_i && hit_status && clr_i) begin
            // clear sets zero, keeps nibble, carry and reset bits
            status_nxt[cso_pkg::ST_BANK_HI:cso_pkg::ST_BANK_LO] = 3'h0;
            status_nxt[cso_pkg::ST_ZERO] = 1'b1;
        end else begin
            if (wr_en_i && hit_status) begin
                status_nxt[cso_pkg::ST_BANK_HI:cso_pkg::ST_BANK_LO] =
                    wdata[cso_pkg::ST_BANK_HI:cso_pkg::ST_BANK_LO];
                for (int i = 0; i <= cso_pkg::ST_ZERO; i++) begin
                    if (!flag_upd_i[i]) begin
                        status_nxt[i] = wdata[i];
                    end
                end
            end
            for (int i = 0; i <= cso_pkg::ST_ZERO; i++) begin
                if (flag_upd_i[i]) begin
                    status_nxt[i] = alu_flags[i];
                end
            end
        end
    end

    // option and interrupt control
    always_comb begin
        option_nxt = option_r;
        if (wr_en_i && hit_option) begin
            option_nxt = wdata;
        end
        ext_meta_nxt = ext_irq_pin_i;
        ext_sync_nxt = ext_meta_r;
        ext_prev_nxt = ext_sync_r;
        ext_edge = option_r[cso_pkg::OP_EXT_EDGE] ? (ext_sync_r & ~ext_prev_r)
                                                  : (~ext_sync_r & ext_prev_r);
        intctl_nxt = intctl_r;
        if (wr_en_i && hit_intctl) begin
            intctl_nxt = wdata;
        end
        // set ignores enables, wins over clear
        if (timer0_ovf_i) begin
            intctl_nxt[cso_pkg::IC_T0_FLAG] = 1'b1;
        end
        if (ext_edge) begin
            intctl_nxt[cso_pkg::IC_EXT_FLAG] = 1'b1;
        end
        if (port_change_i) begin
            intctl_nxt[cso_pkg::IC_PORT_FLAG] = 1'b1;
        end
    end

    // outputs and read data
    always_comb begin
        pullup_nxt = option_r[cso_pkg::OP_PULLUP_DIS] ? 8'h00 : port_latch_i;
        irq_nxt = intctl_r[cso_pkg::IC_GLOBAL_EN] &&
            ((intctl_r[cso_pkg::IC_T0_EN] && intctl_r[cso_pkg::IC_T0_FLAG]) ||
             (intctl_r[cso_pkg::IC_EXT_EN] && intctl_r[cso_pkg::IC_EXT_FLAG]) ||
             (intctl_r[cso_pkg::IC_PORT_EN] && intctl_r[cso_pkg::IC_PORT_FLAG]) ||
             (intctl_r[cso_pkg::IC_PERIPH_EN] && periph_irq_i));
        t0_inc_nxt = presc_link.timer0_inc;
        wdt_inc_nxt = presc_link.wdt_inc;
        rd_data_nxt = rd_data_r;
        if (rd_en_i) begin
            // unmapped addresses read zero
            if (hit_status) begin
                rd_data_nxt = status_r;
            end else if (hit_option) begin
                rd_data_nxt = option_r;
            end else if (hit_intctl) begin
                rd_data_nxt = intctl_r;
            end else begin
                rd_data_nxt = 8'h00;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            status_r <= cso_pkg::STATUS_RST;
            option_r <= cso_pkg::OPTION_RST;
            intctl_r <= cso_pkg::INTCTL_RST;
            rd_data_r <= 8'h00;
            pullup_r <= 8'h00;
            irq_r <= 1'b0;
            t0_inc_r <= 1'b0;
            wdt_inc_r <= 1'b0;
            ext_meta_r <= 1'b0;
            ext_sync_r <= 1'b0;
            ext_prev_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            option_r <= option_nxt;
            intctl_r <= intctl_nxt;
            rd_data_r <= rd_data_nxt;
            pullup_r <= pullup_nxt;
            irq_r <= irq_nxt;
            t0_inc_r <= t0_inc_nxt;
            wdt_inc_r <= wdt_inc_nxt;
            ext_meta_r <= ext_meta_nxt;
            ext_sync_r <= ext_sync_nxt;
            ext_prev_r <= ext_prev_nxt;
        end
    end

    assign rd_data_o = rd_data_r;
    assign bank_sel_o = status_r[cso_pkg::ST_BANK_HI:cso_pkg::ST_BANK_LO];
    assign pullup_en_o = pullup_r;
    assign timer0_inc_o = t0_inc_r;
    assign wdt_inc_o = wdt_inc_r;
    assign irq_o = irq_r;
endmodule : cso_core_regs

/* File: cso_core_regs_properties.sv */
// port assertions for the core register block
`timescale 1ns/1ps
module cso_core_regs_properties (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // watched ports
    input wire logic [8:0] addr_i,
    input wire logic wr_en_i,
    input wire logic clr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic rd_en_i,
    input wire logic [7:0] rd_data_o,
    input wire logic [2:0] bank_sel_o,
    input wire logic [7:0] pullup_en_o,
    input wire logic [7:0] port_latch_i,
    input wire logic [2:0] flag_upd_i
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    logic st_hit, st_wr, opt_off, mapped, clr_ok;
    logic [2:0] wr_bank;
    assign st_hit = addr_i[6:0] == cso_pkg::STATUS_LOW;
    assign st_wr = wr_en_i && st_hit;
    assign wr_bank = wr_data_i[7:5];
    assign opt_off = wr_en_i && !clr_i && addr_i[7:0] == cso_pkg::OPTION_LOW && wr_data_i[7];
    assign mapped = st_hit || addr_i[7:0] == cso_pkg::OPTION_LOW
        || addr_i[6:0] == cso_pkg::INTCTL_LOW;
    assign clr_ok = rd_data_o[7:5] == 3'h0 && rd_data_o[cso_pkg::ST_ZERO];
    sequence clear_s;
        st_wr && clr_i;
    endsequence
    // idle cycle: no write and no flag update may disturb the cleared bits
    sequence settle_s;
        !wr_en_i && flag_upd_i == 3'h0;
    endsequence
    sequence read_s;
        rd_en_i && st_hit;
    endsequence
    bank_write_a: assert property (st_wr && !clr_i |=> bank_sel_o == $past(wr_bank))
        else $error("bank bits differ from write");
    bank_hold_a: assert property (!$stable(bank_sel_o) |-> $past(st_wr))
        else $error("bank bits moved without write");
    bank_clear_a: assert property (clear_s |=> bank_sel_o == 3'h0)
        else $error("clear left bank bits");
    clr_read_a: assert property (clear_s ##1 settle_s ##1 read_s |=> clr_ok)
        else $error("cleared status reads wrong");
    unmapped_read_a: assert property (rd_en_i && !mapped |=> rd_data_o == 8'h00)
        else $error("unmapped read not zero");
    read_hold_a: assert property (!$past(rd_en_i) |-> $stable(rd_data_o))
        else $error("read data moved without read");
    pullup_latch_a: assert property ((pullup_en_o & ~$past(port_latch_i)) == 8'h00)
        else $error("pull-up on with latch low");
    pullup_off_a: assert property (opt_off |=> ##1 pullup_en_o == 8'h00)
        else $error("pull-ups not disabled");
endmodule : cso_core_regs_properties
bind cso_core_regs cso_core_regs_properties cso_core_regs_properties_inst (.*);

/* File: tb.sv */
// self-checking bench for the core register block
`timescale 1ns/1ps
module tb;
    logic clk_sys_i, reset_i, wr_en_i, clr_i, rd_en_i, alu_sub_i, alu_zero_i;
    logic alu_nibble_i, alu_carry_i, sleep_i, wdt_timeout_i, wdt_clear_i, ext_irq_pin_i;
    logic timer_ext_clock_pin_i, cycle_tick_i, wdt_base_tick_i, timer0_ovf_i;
    logic port_change_i, periph_irq_i, timer0_inc_o, wdt_inc_o, irq_o;
    logic [8:0] addr_i;
    logic [7:0] wr_data_i, rd_data_o, port_latch_i, pullup_en_o;
    logic [2:0] flag_upd_i, bank_sel_o;
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;

    cso_core_regs cso_core_regs_inst (.*);

    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    // ceiling well above the roughly 1100 cycles of the run
    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_errors++;
            stop_test();
        end
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // flag_upd_i is a pulse paired with the write
    task automatic wr(input logic [8:0] a, input logic [7:0] d, input logic c);
        addr_i <= a;
        wr_data_i <= d;
        clr_i <= c;
        wr_en_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_en_i <= 1'b0;
        clr_i <= 1'b0;
        flag_upd_i <= 3'h0;
        @(posedge clk_sys_i);
    endtask : wr

    task automatic rdc(input logic [8:0] a, input logic [7:0] exp);
        addr_i <= a;
        rd_en_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_en_i <= 1'b0;
        @(negedge clk_sys_i);
        chk(rd_data_o, exp);
        @(posedge clk_sys_i);
    endtask : rdc

    task automatic t_status;
        wr(9'h183, 8'hE7, 1'b0);
        rdc(9'h003, 8'hFF);
        chk({5'h00, bank_sel_o}, 8'h07);
        wr(9'h083, 8'hFF, 1'b1);
        rdc(9'h103, 8'h1F);
        sleep_i <= 1'b1;
        @(posedge clk_sys_i);
        sleep_i <= 1'b0;
        rdc(9'h003, 8'h17);
        wdt_timeout_i <= 1'b1;
        @(posedge clk_sys_i);
        wdt_timeout_i <= 1'b0;
        rdc(9'h183, 8'h07);
        {flag_upd_i, alu_sub_i, alu_zero_i, alu_nibble_i, alu_carry_i} <= 7'h7A;
        wr(9'h003, 8'hFF, 1'b0);
        rdc(9'h003, 8'hE1);
        {flag_upd_i, alu_sub_i, alu_zero_i, alu_nibble_i, alu_carry_i} <= 7'h15;
        wr(9'h003, 8'h00, 1'b0);
        rdc(9'h083, 8'h01);
        wdt_clear_i <= 1'b1;
        @(posedge clk_sys_i);
        wdt_clear_i <= 1'b0;
        rdc(9'h103, 8'h19);
        $display("status test done");
    endtask : t_status

    // power-of-two windows make the count independent of prescaler phase
    task automatic t_count(input logic [7:0] opt, input logic pin, input logic [7:0] e_t0,
                           input logic [7:0] e_wdt);
        logic [7:0] a;
        logic [7:0] b;
        a = 8'h00;
        b = 8'h00;
        timer_ext_clock_pin_i <= 1'b0;
        wr(9'h081, opt, 1'b0);
        repeat (24) @(posedge clk_sys_i);
        for (int i = 0; i < 64; i++) begin
            if (pin && i % 4 == 0 && i < 52) begin
                timer_ext_clock_pin_i <= ~timer_ext_clock_pin_i;
            end
            @(negedge clk_sys_i);
            a += {7'h00, timer0_inc_o};
            b += {7'h00, wdt_inc_o};
            @(posedge clk_sys_i);
        end
        chk(a, e_t0);
        chk(b, e_wdt);
    endtask : t_count

    task automatic t_irq;
        wr(9'h081, 8'hC0, 1'b0);
        {timer0_ovf_i, port_change_i, ext_irq_pin_i} <= 3'h7;
        @(posedge clk_sys_i);
        {timer0_ovf_i, port_change_i} <= 2'h0;
        repeat (6) @(posedge clk_sys_i);
        rdc(9'h08B, 8'h07);
        rdc(9'h18B, 8'h07);
        chk({7'h00, irq_o}, 8'h00);
        ext_irq_pin_i <= 1'b0;
        wr(9'h10B, 8'h00, 1'b0);
        repeat (6) @(posedge clk_sys_i);
        rdc(9'h00B, 8'h00);
        wr(9'h18B, 8'h38, 1'b0);
        rdc(9'h00B, 8'h38);
        periph_irq_i <= 1'b1;
        wr(9'h00B, 8'h80, 1'b0);
        chk({7'h00, irq_o}, 8'h00);
        wr(9'h00B, 8'hC0, 1'b0);
        @(negedge clk_sys_i);
        chk({7'h00, irq_o}, 8'h01);
        @(posedge clk_sys_i);
        $display("interrupt test done");
    endtask : t_irq

    task automatic t_reset;
        rdc(9'h003, 8'h18);
        rdc(9'h181, 8'hFF);
        rdc(9'h004, 8'h00);
        chk(pullup_en_o, 8'h00);
        $display("reset test done");
    endtask : t_reset

    task automatic t_pullup;
        wr(9'h181, 8'h40, 1'b0);
        @(negedge clk_sys_i);
        chk(pullup_en_o, 8'hA5);
        @(posedge clk_sys_i);
        rdc(9'h081, 8'h40);
        $display("pull-up test done");
    endtask : t_pullup

    // watchdog runs undivided while the timer owns the prescaler
    task automatic t_presc;
        for (int r = 0; r < 4; r++) begin
            t_count(8'hC0 | 8'(r), 1'b0, 8'(64 >> (r + 1)), 8'h40);
            t_count(8'hC8 | 8'(r), 1'b0, 8'h40, 8'(64 >> r));
        end
        t_count(8'hE8, 1'b0, 8'h00, 8'h40);
        t_count(8'hE8, 1'b1, 8'h07, 8'h40);
        t_count(8'hF8, 1'b1, 8'h06, 8'h40);
        $display("prescaler test done");
    endtask : t_presc

    initial begin
        {wr_en_i, clr_i, rd_en_i, alu_sub_i, alu_zero_i, alu_nibble_i, alu_carry_i} = 7'h00;
        {sleep_i, wdt_timeout_i, wdt_clear_i, ext_irq_pin_i, timer_ext_clock_pin_i} = 5'h00;
        {timer0_ovf_i, port_change_i, periph_irq_i, addr_i, wr_data_i} = 20'h00000;
        {cycle_tick_i, wdt_base_tick_i, flag_upd_i} = 5'h18;
        port_latch_i = 8'hA5;
        reset_i = 1'b1;
        repeat (16) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        @(posedge clk_sys_i);
        t_reset();
        t_status();
        t_pullup();
        t_presc();
        t_irq();
        stop_test();
    end
endmodule : tb
